// *** hw/ucstx_top.sv ***
// uart clock select, control register and transmit interrupt with axi slave
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
module ucstx_top
  import ucstx_pkg::*;
#(
  parameter int DEPTH = UCSTX_FIFO_DEPTH,
  parameter int WORD_TICKS = UCSTX_WORD_TICKS
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmit side and interrupts
  output logic baud_tick,
  output logic [7:0] tx_shift_data,
  output logic tx_fifo_empty_irq,
  output logic irq
);
  import ucstx_pkg::*;

  // write channel capture
  logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  ucstx_wreq_t wq_reg, wq_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  // register state
  logic [7:0] mode_reg, mode_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic tx_fifo_below_trigger_flag_reg, tx_fifo_below_trigger_flag_next;
  logic tx_fifo_below_trigger_flag_seen_reg, tx_fifo_below_trigger_flag_seen_next;
  logic [4:0] trig_reg, trig_next;
  logic [UCSTX_EV_NUM-1:0] ists_reg, ists_next, imsk_reg, imsk_next;
  logic below_q_reg, below_q_next;
  // strobes
  logic wr_fire, rd_fire, push, flush;
  logic [7:0] push_data;
  logic [31:0] wmask;
  ucstx_txstat_t txs;
  ucstx_cks_t cks;
  logic tx_fifo_below_trigger_flag_rise;

  // expand byte strobes to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // merge masked write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  // prescale selection comes straight from mode bits 1..0
  assign cks = ucstx_cks_t'(mode_reg[UCSTX_MODE_CKS_LSB +: 2]);

  ucstx_prescale u_pre (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .sel(cks),
    .tick(baud_tick)
  );

  ucstx_txfifo #(
    .DEPTH(DEPTH),
    .WORD_TICKS(WORD_TICKS)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .push(push),
    .push_data(push_data),
    .flush(flush),
    .tick(baud_tick),
    .trig(trig_reg),
    .stat(txs),
    .shift_data(tx_shift_data)
  );

  // axi handshakes: accept aw and w independently, respond after both
  // a low enable withholds every ready so nothing is taken and then lost
  always_comb begin
    s_axi_awready = clk_en && !aw_got_reg && !bvalid_reg;
    s_axi_wready = clk_en && !w_got_reg && !bvalid_reg;
    s_axi_arready = clk_en && !rvalid_reg;
    aw_got_next = aw_got_reg;
    w_got_next = w_got_reg;
    wq_next = wq_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next = 1'b1;
      wq_next.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next = 1'b1;
      wq_next.data = s_axi_wdata;
      wq_next.strb = s_axi_wstrb;
    end
    wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
    rd_fire = s_axi_arvalid && s_axi_arready;
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next = 1'b0;
    end
  end

  // register writes, hardware events and flag behaviour
  always_comb begin
    wmask = strb_mask(wq_reg.strb);
    mode_next = mode_reg;
    ctrl_next = ctrl_reg;
    trig_next = trig_reg;
    imsk_next = imsk_reg;
    bresp_next = bresp_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    push = 1'b0;
    push_data = wq_reg.data[7:0];
    flush = 1'b0;
    tx_fifo_below_trigger_flag_seen_next = tx_fifo_below_trigger_flag_seen_reg;
    below_q_next = txs.below_trig;
    // edge of the below-trigger level, for the event bit
    tx_fifo_below_trigger_flag_rise = txs.below_trig && !below_q_reg;
    tx_fifo_below_trigger_flag_next = tx_fifo_below_trigger_flag_reg;
    ists_next = ists_reg;
    // the prior read and the fifo level gate the flag clear: it needs the level at or above the trigger count
    if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next = UCSTX_RESP_OKAY;
      unique case (wq_reg.addr)
        UCSTX_OFF_MODE: mode_next = 8'(merge(32'(mode_reg), wq_reg.data,
                           wmask & 32'(UCSTX_MODE_WMASK)));
        UCSTX_OFF_CTRL: ctrl_next = 16'(merge(32'(ctrl_reg), wq_reg.data,
                           wmask & 32'(UCSTX_CTRL_WMASK)));
        UCSTX_OFF_STAT: begin
          // flag clears only by writing 0 after reading it as 1
          if (wq_reg.strb[0] && !wq_reg.data[UCSTX_STAT_TX_FIFO_BELOW_TRIGGER_FLAG_BIT]
              && tx_fifo_below_trigger_flag_seen_reg && !txs.below_trig) begin
            tx_fifo_below_trigger_flag_next = 1'b0;
            tx_fifo_below_trigger_flag_seen_next = 1'b0;
          end
          flush = wq_reg.strb[1] && wq_reg.data[8];
        end
        UCSTX_OFF_FIFO: push = wq_reg.strb[0];
        UCSTX_OFF_TRIG: if (wq_reg.strb[0]) trig_next = wq_reg.data[4:0];
        UCSTX_OFF_IRQS: ists_next = ists_reg & ~wq_reg.data[1:0];
        UCSTX_OFF_IRQM: if (wq_reg.strb[0]) imsk_next = wq_reg.data[1:0];
        default: bresp_next = UCSTX_RESP_SLVERR;
      endcase
    end
    // set wins over any clear in the same cycle
    if (txs.load || tx_fifo_below_trigger_flag_rise || txs.below_trig) begin
      tx_fifo_below_trigger_flag_next = 1'b1;
    end
    if (tx_fifo_below_trigger_flag_rise) ists_next[UCSTX_EV_TX_FIFO_BELOW_TRIGGER_FLAG] = 1'b1;
    if (txs.load) ists_next[UCSTX_EV_LOAD] = 1'b1;
  end

  // read data mux; reserved bits come back zero
  always_comb begin
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = UCSTX_RESP_OKAY;
      unique case (s_axi_araddr)
        UCSTX_OFF_MODE: rdata_next = 32'(mode_reg & UCSTX_MODE_WMASK);
        UCSTX_OFF_CTRL: rdata_next = 32'(ctrl_reg & UCSTX_CTRL_WMASK);
        UCSTX_OFF_STAT:
          rdata_next = 32'(tx_fifo_below_trigger_flag_reg) << UCSTX_STAT_TX_FIFO_BELOW_TRIGGER_FLAG_BIT;
        UCSTX_OFF_FIFO: rdata_next = 32'(txs.level);
        UCSTX_OFF_TRIG: rdata_next = 32'(trig_reg);
        UCSTX_OFF_IRQS: rdata_next = 32'(ists_reg);
        UCSTX_OFF_IRQM: rdata_next = 32'(imsk_reg);
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = UCSTX_RESP_SLVERR;
        end
      endcase
    end
  end

  // reading the flag as 1 arms the clear; the write must come later
  logic arm_read;
  assign arm_read = rd_fire && s_axi_araddr == UCSTX_OFF_STAT && tx_fifo_below_trigger_flag_reg;

  // state registers; a low enable freezes everything, bus included
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      wq_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= UCSTX_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= UCSTX_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      mode_reg <= 8'h00;
      ctrl_reg <= UCSTX_CTRL_RST;
      tx_fifo_below_trigger_flag_reg <= 1'b0;
      tx_fifo_below_trigger_flag_seen_reg <= 1'b0;
      trig_reg <= UCSTX_TRIG_RST;
      ists_reg <= '0;
      imsk_reg <= '0;
      below_q_reg <= 1'b1; // empty fifo idles below trigger, no false edge
    end else if (clk_en) begin
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      wq_reg <= wq_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      mode_reg <= mode_next;
      ctrl_reg <= ctrl_next;
      tx_fifo_below_trigger_flag_reg <= tx_fifo_below_trigger_flag_next;
      tx_fifo_below_trigger_flag_seen_reg <= tx_fifo_below_trigger_flag_seen_next || arm_read;
      trig_reg <= trig_next;
      ists_reg <= ists_next;
      imsk_reg <= imsk_next;
      below_q_reg <= below_q_next;
    end
  end

  // outputs: level request gated by enable, summary irq
  assign tx_fifo_empty_irq = ctrl_reg[UCSTX_CTRL_TIE_BIT] && tx_fifo_below_trigger_flag_reg;
  assign irq = |(ists_reg & imsk_reg);
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // reserved bits read back zero; reset clears control
  AST_MODE_RSV_ZERO: assert property (@(posedge clk)
    disable iff (!arst_n)
    s_axi_rvalid && $past(s_axi_araddr) == UCSTX_OFF_MODE && $past(rd_fire)
      |-> s_axi_rdata[UCSTX_MODE_RSV_BIT] == 1'b0)
    else $error("mode reserved bit read nonzero");
  AST_CTRL_RSV_ZERO: assert property (@(posedge clk)
    disable iff (!arst_n)
    ctrl_reg[15:8] == 8'h00)
    else $error("control upper byte nonzero");
  AST_CTRL_RSV_READ: assert property (@(posedge clk)
    disable iff (!arst_n)
    s_axi_rvalid && $past(s_axi_araddr) == UCSTX_OFF_CTRL && $past(rd_fire)
      |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("control read shows reserved bits");
  AST_CTRL_RESET: assert property (@(posedge clk)
    !arst_n |=>
      ctrl_reg == UCSTX_CTRL_RST || !arst_n)
    else $error("control not cleared by reset");

  // bus always answers, and stays quiet while frozen
  AST_WRITE_ANSWER: assert property (@(posedge clk)
    disable iff (!arst_n)
    (wr_fire && clk_en) |=> s_axi_bvalid)
    else $error("write not answered");
  AST_READ_ANSWER: assert property (@(posedge clk)
    disable iff (!arst_n)
    rd_fire |=> s_axi_rvalid)
    else $error("read not answered");
  AST_FREEZE_NO_READY: assert property (@(posedge clk)
    disable iff (!arst_n)
    !clk_en |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("handshake offered while frozen");

  // request level and the events that raise or withdraw it
  AST_TIE_GATES: assert property (@(posedge clk)
    disable iff (!arst_n)
    !ctrl_reg[UCSTX_CTRL_TIE_BIT] |-> !tx_fifo_empty_irq)
    else $error("request while enable clear");
  AST_LOAD_SETS: assert property (@(posedge clk)
    disable iff (!arst_n)
    txs.load |=> tx_fifo_below_trigger_flag_reg)
    else $error("load did not raise flag");
  AST_BELOW_SETS: assert property (@(posedge clk)
    disable iff (!arst_n)
    (txs.below_trig && clk_en) |=> tx_fifo_below_trigger_flag_reg)
    else $error("below trigger did not raise flag");
  AST_IRQ_LEVEL: assert property (@(posedge clk)
    disable iff (!arst_n)
    (ctrl_reg[UCSTX_CTRL_TIE_BIT] && tx_fifo_below_trigger_flag_reg) == tx_fifo_empty_irq)
    else $error("request differs from enable and flag");
  AST_CLEAR_NEEDS_READ: assert property (@(posedge clk)
    disable iff (!arst_n)
    ($fell(tx_fifo_below_trigger_flag_reg)) |-> $past(tx_fifo_below_trigger_flag_seen_reg))
    else $error("flag cleared without prior read");

  // main scenarios reached
  COV_LOAD: cover property (@(posedge clk) disable iff (!arst_n) txs.load);
  COV_IRQ: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(tx_fifo_empty_irq));
  COV_CLEAR: cover property (@(posedge clk) disable iff (!arst_n)
    $fell(tx_fifo_below_trigger_flag_reg));
  COV_DIV64: cover property (@(posedge clk) disable iff (!arst_n)
    cks == UCSTX_CKS_DIV64 && baud_tick);
  COV_FLUSH: cover property (@(posedge clk) disable iff (!arst_n)
    flush && clk_en);

endmodule // ucstx_top

// *** hw/ucstx_pkg.sv ***
// package: register map, field layout and constants for the uart control block
package ucstx_pkg;

  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] UCSTX_OFF_MODE = 8'h00;
  localparam logic [7:0] UCSTX_OFF_CTRL = 8'h04;
  localparam logic [7:0] UCSTX_OFF_STAT = 8'h08;
  localparam logic [7:0] UCSTX_OFF_FIFO = 8'h0c;
  localparam logic [7:0] UCSTX_OFF_TRIG = 8'h10;
  localparam logic [7:0] UCSTX_OFF_IRQS = 8'h14;
  localparam logic [7:0] UCSTX_OFF_IRQM = 8'h18;

  // mode register fields
  localparam int UCSTX_MODE_CKS_LSB = 0;
  localparam int UCSTX_MODE_RSV_BIT = 2;
  localparam logic [7:0] UCSTX_MODE_WMASK = 8'hfb;

  // control register fields
  localparam int UCSTX_CTRL_TIE_BIT = 7;
  localparam logic [15:0] UCSTX_CTRL_WMASK = 16'h00ff;
  localparam logic [15:0] UCSTX_CTRL_RST = 16'h0000;

  // status register field
  localparam int UCSTX_STAT_TX_FIFO_BELOW_TRIGGER_FLAG_BIT = 5;

  // interrupt status bits
  localparam int UCSTX_EV_TX_FIFO_BELOW_TRIGGER_FLAG = 0;
  localparam int UCSTX_EV_LOAD = 1;
  localparam int UCSTX_EV_NUM = 2;

  // axi responses
  localparam logic [1:0] UCSTX_RESP_OKAY = 2'h0;
  localparam logic [1:0] UCSTX_RESP_SLVERR = 2'h2;

  // prescaler ratios
  localparam int UCSTX_DIV4 = 4;
  localparam int UCSTX_DIV16 = 16;
  localparam int UCSTX_DIV64 = 64;

  // fifo defaults
  localparam int UCSTX_FIFO_DEPTH = 16;
  localparam logic [4:0] UCSTX_TRIG_RST = 5'h01;
  // shift register hold time in prescaled ticks per word
  localparam int UCSTX_WORD_TICKS = 10;

  // prescale codes
  typedef enum logic [1:0] {
    UCSTX_CKS_DIV1,
    UCSTX_CKS_DIV4,
    UCSTX_CKS_DIV16,
    UCSTX_CKS_DIV64
  } ucstx_cks_t;

  // axi write request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ucstx_wreq_t;

  // transmit status carried out of the fifo
  typedef struct packed {
    logic [4:0] level;
    logic below_trig;
    logic load;
  } ucstx_txstat_t;

endpackage

// *** hw/ucstx_prescale.sv ***
// baud prescaler: one-cycle tick at pclk/1, /4, /16 or /64
`timescale 1ns/100ps
module ucstx_prescale
  import ucstx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // selection and tick
  input wire ucstx_pkg::ucstx_cks_t sel,
  output logic tick
);
  import ucstx_pkg::*;

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [5:0] last;

  // terminal count per selected ratio
  always_comb begin
    unique case (sel)
      UCSTX_CKS_DIV1: last = 6'h00;
      UCSTX_CKS_DIV4: last = 6'(UCSTX_DIV4 - 1);
      UCSTX_CKS_DIV16: last = 6'(UCSTX_DIV16 - 1);
      UCSTX_CKS_DIV64: last = 6'(UCSTX_DIV64 - 1);
    endcase
  end

  // free-running counter, restarts at terminal count
  always_comb begin
    tick = (cnt_reg >= last);
    cnt_next = tick ? 6'h00 : cnt_reg + 6'h01;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 6'h00;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
    end
  end

  AST_DIV64_SPACING: assert property (@(posedge clk)
    disable iff (!arst_n)
    (clk_en && tick && sel == UCSTX_CKS_DIV64 && $stable(sel)) |=>
      (!tick || sel != UCSTX_CKS_DIV64))
    else $error("div64 tick repeated too soon");

endmodule // ucstx_prescale

// *** hw/ucstx_txfifo.sv ***
// transmit fifo with a shift register drain paced by the prescaler
`timescale 1ns/100ps
module ucstx_txfifo
  import ucstx_pkg::*;
#(
  parameter int DEPTH = UCSTX_FIFO_DEPTH,
  parameter int WORD_TICKS = UCSTX_WORD_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // write side from software
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic flush,
  // pacing and trigger
  input wire logic tick,
  input wire logic [4:0] trig,
  // state out
  output ucstx_pkg::ucstx_txstat_t stat,
  output logic [7:0] shift_data
);
  import ucstx_pkg::*;

  logic [7:0] mem_reg [DEPTH];
  logic [3:0] rd_reg, rd_next, wr_reg, wr_next;
  logic [4:0] lvl_reg, lvl_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] tk_reg, tk_next;
  logic busy_reg, busy_next;
  logic pop, do_push;

  // shift register takes a word when idle; push refused when full
  always_comb begin
    do_push = push && (lvl_reg < 5'(DEPTH));
    pop = !busy_reg && (lvl_reg != 5'h00);
    rd_next = pop ? rd_reg + 4'h1 : rd_reg;
    wr_next = do_push ? wr_reg + 4'h1 : wr_reg;
    lvl_next = lvl_reg + 5'(do_push) - 5'(pop);
    sh_next = pop ? mem_reg[rd_reg] : sh_reg;
    busy_next = busy_reg;
    tk_next = tk_reg;
    if (pop) begin
      busy_next = 1'b1;
      tk_next = 8'h00;
    end else if (busy_reg && tick) begin
      tk_next = tk_reg + 8'h01;
      busy_next = (tk_reg != 8'(WORD_TICKS - 1));
    end
    if (flush) begin
      rd_next = 4'h0;
      wr_next = 4'h0;
      lvl_next = 5'h00;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_reg <= 4'h0;
      wr_reg <= 4'h0;
      lvl_reg <= 5'h00;
      sh_reg <= 8'h00;
      tk_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      lvl_reg <= lvl_next;
      sh_reg <= sh_next;
      tk_reg <= tk_next;
      busy_reg <= busy_next;
    end
  end

  // storage has no reset, only written words are ever read
  always_ff @(posedge clk) begin
    if (clk_en && do_push) begin
      mem_reg[wr_reg] <= push_data;
    end
  end

  // load pulse marks fifo to shift register transfer
  always_comb begin
    stat.level = lvl_reg;
    stat.below_trig = (lvl_reg < trig);
    stat.load = pop && clk_en;
    shift_data = sh_reg;
  end

endmodule // ucstx_txfifo

// *** test/ucstx_far_model.sv ***
// far-side listener that collects each word entering the shift register
`timescale 1ns/100ps
module ucstx_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serial side of the block
  input wire logic [7:0] shift_data,
  // what was heard
  output logic [7:0] word_count,
  output logic [7:0] last_word
);
  logic [7:0] prev_reg, prev_next, count_reg, count_next;

  // a new word shows as a change; equal neighbours count once, so vary data
  always_comb begin
    prev_next = shift_data;
    count_next = count_reg;
    if (shift_data !== prev_reg) begin
      count_next = count_reg + 8'h01;
    end
  end

  // listener state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= 8'h00;
      count_reg <= 8'h00;
    end else begin
      prev_reg <= prev_next;
      count_reg <= count_next;
    end
  end

  // outputs
  assign word_count = count_reg;
  assign last_word = prev_reg;
endmodule // ucstx_far_model

// *** test/test_uart_clock_select_tx_irq.sv ***
// self-checking bench for the uart clock select and transmit interrupt
`timescale 1ns/100ps
module test_uart_clock_select_tx_irq;
  import ucstx_pkg::*;
  logic clk, arst_n, clk_en;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tx_shift_data, rx_count, rx_last;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, baud_tick, tx_fifo_empty_irq, irq;
  int err_total, check_count;

  // short word hold keeps the drain quick
  ucstx_top #(.WORD_TICKS(2)) i_ucstx_top (
    .clk, .arst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .baud_tick, .tx_shift_data, .tx_fifo_empty_irq, .irq);
  ucstx_far_model i_ucstx_far_model (.clk, .arst_n,
    .shift_data(tx_shift_data), .word_count(rx_count), .last_word(rx_last));

  // 250 mhz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic final_report();
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang(input string m);
    $display("BAD %0t timeout %s", $time, m);
    err_total++;
    final_report();
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      err_total++;
    end
  endtask

  // sample at the falling edge so the next rising edge sees the same values
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ha, hw, hb;
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      n++;
      if (n > 50) hang("write");
    end while (!hb);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdx(input logic [7:0] a);
    bit ha, hr;
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ha) s_axi_arvalid <= 1'b0;
      n++;
      if (n > 50) hang("read");
    end while (!hr);
    s_axi_rready <= 1'b0;
  endtask

  task automatic scn_reset();
    rdx(UCSTX_OFF_CTRL);
    chk(rd, 32'h0, "ctrl reset");
    chk({30'h0, tx_fifo_empty_irq, irq}, 32'h0, "irq reset");
  endtask

  task automatic scn_regs();
    wr(UCSTX_OFF_CTRL, 32'h0000ff7f);
    rdx(UCSTX_OFF_CTRL);
    chk(rd, 32'h7f, "ctrl upper byte");
    chk({31'h0, tx_fifo_empty_irq}, 32'h0, "gate closed");
    wr(UCSTX_OFF_MODE, 32'h000000fc);
    rdx(UCSTX_OFF_MODE);
    chk(rd, 32'hf8, "mode bit 2");
    wr(UCSTX_OFF_CTRL, 32'h0);
  endtask

  // tick spacing for every select code
  task automatic scn_prescale();
    int g, n;
    for (int c = 0; c < 4; c++) begin
      wr(UCSTX_OFF_MODE, 32'(c));
      n = 0;
      g = 0;
      @(negedge clk);
      while (!baud_tick && n < 200) begin
        @(negedge clk);
        n++;
      end
      do begin
        @(negedge clk);
        g++;
      end while (!baud_tick && g < 200);
      chk(32'(g), 32'(1 << (2 * c)), "tick period");
    end
  endtask

  // slow /64 drain leaves room to clear the flag while words wait
  task automatic scn_txirq();
    int n;
    wr(UCSTX_OFF_CTRL, 32'h80);
    chk({31'h0, tx_fifo_empty_irq}, 32'h1, "enable raises");
    wr(UCSTX_OFF_CTRL, 32'h0);
    chk({31'h0, tx_fifo_empty_irq}, 32'h0, "enable cleared");
    wr(UCSTX_OFF_CTRL, 32'h80);
    for (int i = 0; i < 4; i++) begin
      wr(UCSTX_OFF_FIFO, 32'ha1 + 32'(i));
    end
    rdx(UCSTX_OFF_STAT);
    chk({31'h0, rd[5]}, 32'h1, "flag set");
    wr(UCSTX_OFF_STAT, 32'h0);
    chk({31'h0, tx_fifo_empty_irq}, 32'h0, "fill and clear");
    wr(UCSTX_OFF_CTRL, 32'h80);
    n = 0;
    while (!tx_fifo_empty_irq && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) hang("drain");
    chk({24'h0, tx_shift_data}, 32'ha2, "second load raises");
    n = 0;
    while (rx_count !== 8'h04 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 3000) hang("drain");
    chk({24'h0, rx_count}, 32'h4, "words loaded");
    chk({24'h0, rx_last}, 32'ha4, "last word heard");
    chk({24'h0, tx_shift_data}, 32'ha4, "last word");
    rdx(UCSTX_OFF_IRQS);
    chk(rd, 32'h3, "events latched");
  endtask

  task automatic scn_irq();
    chk({31'h0, irq}, 32'h0, "masked");
    wr(UCSTX_OFF_IRQM, 32'h2);
    chk({31'h0, irq}, 32'h1, "unmasked");
    wr(UCSTX_OFF_IRQS, 32'h2);
    rdx(UCSTX_OFF_IRQS);
    chk(rd, 32'h1, "one to clear");
    chk({31'h0, irq}, 32'h0, "cleared");
    rdx(8'h40);
    chk(rd, 32'h0, "read unmapped data");
    chk({30'h0, rs}, {30'h0, UCSTX_RESP_SLVERR}, "read unmapped");
    wr(8'h40, 32'h0);
    chk({30'h0, rs}, {30'h0, UCSTX_RESP_SLVERR}, "write unmapped");
  endtask

  // trigger count, fifo level, below-trigger request and flush
  task automatic scn_fifo();
    repeat (130) @(posedge clk);
    wr(UCSTX_OFF_TRIG, 32'h4);
    rdx(UCSTX_OFF_TRIG);
    chk(rd, 32'h4, "trigger count");
    for (int i = 0; i < 3; i++) begin
      wr(UCSTX_OFF_FIFO, 32'hb1 + 32'(i));
    end
    rdx(UCSTX_OFF_FIFO);
    chk(rd, 32'h2, "fifo level");
    chk({31'h0, tx_fifo_empty_irq}, 32'h1, "below trigger raises");
    wr(UCSTX_OFF_STAT, 32'h100);
    rdx(UCSTX_OFF_FIFO);
    chk(rd, 32'h0, "flushed");
  endtask

  // frozen enable offers no handshake; mid-run reset clears control
  task automatic scn_freeze();
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (4) @(negedge clk);
    chk({29'h0, s_axi_awready, s_axi_wready, s_axi_arready}, 32'h0,
        "frozen bus");
    @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rdx(UCSTX_OFF_CTRL);
    chk(rd, 32'h0, "ctrl after reset");
    rdx(UCSTX_OFF_TRIG);
    chk(rd, 32'(UCSTX_TRIG_RST), "trigger after reset");
  endtask

  // main sequence
  initial begin
    err_total = 0;
    check_count = 0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    scn_reset();
    scn_regs();
    scn_prescale();
    scn_txirq();
    scn_irq();
    scn_fifo();
    scn_freeze();
    final_report();
  end
endmodule // test_uart_clock_select_tx_irq
